/* bench/pbdr_properties.sv */
`timescale 1ns/10ps
module pbdr_checker
	import pbdr_pkg::*;
#(
	parameter int RESET_CYCLES = RESET_PULSE_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [9:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pslverr_out,
	input wire logic diag_done_in,
	input wire logic [7:0] ipg_len_out,
	input wire logic [10:0] pkt_len_out,
	input wire logic diag_start_out,
	input wire logic phy_reset_out,
	input wire logic phy_restart_out
);
	localparam int HI_MAX = RESET_CYCLES + 3;
	logic wr;
	assign wr = psel_in && penable_in && pwrite_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence held_s(x);
		x ##[1:HI_MAX] !x;
	endsequence
	sequence launch_s;
		wr && paddr_in == {IDX_CABLE_DIAG, 2'h0} && pwdata_in[15] && !diag_start_out
			&& !phy_restart_out && !phy_reset_out;
	endsequence
	chk_reset_pulse: assert property ($rose(phy_reset_out) |=> held_s(phy_reset_out))
		else $error("soft reset pulse length wrong");
	chk_restart_pulse: assert property ($rose(phy_restart_out) |=> held_s(phy_restart_out))
		else $error("soft restart pulse length wrong");
	chk_diag_launch: assert property (launch_s |=> diag_start_out)
		else $error("start write did not launch");
	chk_start_holds: assert property (diag_start_out && !diag_done_in && !wr && !phy_restart_out
		&& !phy_reset_out |=> diag_start_out) else $error("start dropped early");
	chk_start_clears: assert property (diag_start_out && diag_done_in |=> !diag_start_out)
		else $error("start not cleared on done");
	chk_gap_cause: assert property ($changed(ipg_len_out) |-> $past(wr) || $past(phy_reset_out)
		|| $past(phy_reset_out, 2)) else $error("gap changed without write");
	chk_len_cause: assert property ($changed(pkt_len_out) |-> $past(wr) || $past(phy_reset_out)
		|| $past(phy_reset_out, 2)) else $error("length changed without write");
	chk_err_access: assert property (pslverr_out |-> psel_in && penable_in)
		else $error("error outside access phase");
endmodule : pbdr_checker

bind pbdr_regs pbdr_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

/* bench/phy_bist_diag_reset_regs_tb.sv */
`timescale 1ns/10ps
module phy_bist_diag_reset_regs_tb
	import pbdr_pkg::*;
;
	localparam logic [9:0] A_GAP = {IDX_ERRCOUNT_GAP, 2'h0};
	localparam logic [9:0] A_LEN = {IDX_PACKET_LENGTH, 2'h0};
	localparam logic [9:0] A_DIAG = {IDX_CABLE_DIAG, 2'h0};
	localparam logic [9:0] A_RST = {IDX_RESET_CONTROL, 2'h0};
	localparam logic [9:0] A_IST = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [9:0] A_IMSK = {IDX_IRQ_MASK, 2'h0};
	logic ref_clk_in = 1'h0, rstn_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, prbs_byte_error_in = 1'h0, prbs_count_mode_in = 1'h0;
	logic selftest_lock_write_in = 1'h0, diag_done_in = 1'h0, diag_fail_in = 1'h0;
	logic [1:0] link_quality_in = 2'h0;
	logic [9:0] paddr_in = 10'h0;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic pready_out, pslverr_out, err, irq_out, diag_start_out, phy_reset_out, phy_restart_out;
	logic [7:0] ipg_len_out;
	logic [10:0] pkt_len_out;
	int num_errors = 0, tests_run = 0, cycles = 0;
	pbdr_regs #(.RESET_CYCLES(4)) dut (.*);
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	task check(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'h1;
		do @(posedge ref_clk_in); while (pready_out !== 1'h1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
	endtask : apb
	task wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task rchk(input logic [9:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check($sformatf("reg %h", a), rd, e);
	endtask : rchk
	task pulse_err(input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			prbs_byte_error_in <= 1'h1;
			@(posedge ref_clk_in);
			prbs_byte_error_in <= 1'h0;
		end
	endtask : pulse_err
	task done(input logic f);
		@(posedge ref_clk_in);
		diag_done_in <= 1'h1;
		diag_fail_in <= f;
		@(posedge ref_clk_in);
		diag_done_in <= 1'h0;
		diag_fail_in <= 1'h0;
	endtask : done
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk_in);
		rstn_in <= 1'h1;
		rchk(A_GAP, 32'h7D);
		rchk(A_LEN, 32'h5DC);
		wr(A_LEN, 32'hFFFFFFFF);
		rchk(A_LEN, 32'h7FF);
		check("pkt_len", 32'(pkt_len_out), 32'h7FF);
		wr(A_RST, 32'h3FFF);
		rchk(A_RST, 32'h0);
		for (int q = 1; q < 4; q++) begin
			link_quality_in <= 2'(q);
			rchk(A_DIAG, 32'(q) << 8);
		end
		wr(A_GAP, 32'h33);
		@(posedge ref_clk_in);
		check("ipg", 32'(ipg_len_out), 32'h33);
		pulse_err(3);
		rchk(A_GAP, 32'h333);
		@(posedge ref_clk_in);
		selftest_lock_write_in <= 1'h1;
		@(posedge ref_clk_in);
		selftest_lock_write_in <= 1'h0;
		pulse_err(2);
		rchk(A_GAP, 32'h333);
		wr(A_GAP, 32'h8033);
		pulse_err(1);
		rchk(A_GAP, 32'h533);
		wr(A_GAP, 32'h33);
		rchk(A_GAP, 32'h133);
		pulse_err(300);
		rchk(A_GAP, 32'hFF33);
		prbs_count_mode_in <= 1'h1;
		pulse_err(1);
		rchk(A_GAP, 32'h0033);
		prbs_count_mode_in <= 1'h0;
		wr(A_DIAG, 32'h8000);
		rchk(A_DIAG, 32'h8300);
		check("start", 32'(diag_start_out), 32'h1);
		done(1'h1);
		rchk(A_DIAG, 32'h303);
		wr(A_DIAG, 32'h8000);
		rchk(A_DIAG, 32'h8300);
		done(1'h0);
		rchk(A_DIAG, 32'h302);
		rchk(A_IST, 32'h7);
		check("irq", 32'(irq_out), 32'h0);
		wr(A_IMSK, 32'h1);
		rchk(A_IMSK, 32'h1);
		check("irq", 32'(irq_out), 32'h1);
		wr(A_IST, 32'h1);
		rchk(A_IST, 32'h6);
		check("irq", 32'(irq_out), 32'h0);
		wr(10'h088, 32'hFFFF);
		check("slverr", 32'(err), 32'h1);
		rchk(10'h088, 32'h0);
		wr(A_RST, 32'h4000);
		rchk(A_RST, 32'h4000);
		while (phy_restart_out !== 1'h0) @(posedge ref_clk_in);
		rchk(A_RST, 32'h0);
		rchk(A_LEN, 32'h7FF);
		wr(A_RST, 32'h8000);
		rchk(A_RST, 32'h8000);
		while (phy_reset_out !== 1'h0) @(posedge ref_clk_in);
		rchk(A_LEN, 32'h5DC);
		rchk(A_IMSK, 32'h0);
		rchk(A_RST, 32'h0);
		close_out();
	end
endmodule : phy_bist_diag_reset_regs_tb

/* core/pbdr_regs.sv */
`timescale 1ns/10ps

// What this block does
// [R1] error byte count in errcount high byte
// [R2] self-test control write freezes shown count
// [R3] count mode zero saturates at 0xFF
// [R4] writing bit15 captures count, clears counter
// [R5] gap byte field drives generator, resets 125
// [R6] 11-bit packet length field, resets 1500
// [R7] reserved bits ignore writes, read zero
// [R8] start bit launches cable measurement
// [R9] start bit clears when done raises
// [R10] done bit set on measurement completion
// [R11] fail bit set when measurement fails
// [R12] two-bit link quality field, read only
// [R13] software trusts quality only with link up
// [R14] bit15 resets whole PHY, self clears
// [R15] bit14 restarts PHY keeping registers except start bit, which it clears; self clears
// [R16] new launch clears done and fail
// [R17] reset bits read zero when finished
module pbdr_regs
	import pbdr_pkg::*;
#(
	parameter int RESET_CYCLES = RESET_PULSE_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [9:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic prbs_byte_error_in,
	input wire logic prbs_count_mode_in,
	input wire logic selftest_lock_write_in,
	input wire logic diag_done_in,
	input wire logic diag_fail_in,
	input wire logic [1:0] link_quality_in,
	output logic [7:0] ipg_len_out,
	output logic [10:0] pkt_len_out,
	output logic diag_start_out,
	output logic phy_reset_out,
	output logic phy_restart_out,
	output logic irq_out
);

	pbdr_state_type s_q;
	pbdr_state_type s_d;
	pbdr_apb_req_type req;
	pbdr_phy_in_type phy;

	function automatic logic [7:0] reg_index(input logic [9:0] addr);
		reg_index = addr[9:2];
	endfunction : reg_index

	function automatic logic mapped(input logic [9:0] addr);
		logic [7:0] idx;
		idx = reg_index(addr);
		mapped = (addr[1:0] == 2'h0) &&
			(idx == IDX_ERRCOUNT_GAP || idx == IDX_PACKET_LENGTH ||
			idx == IDX_CABLE_DIAG || idx == IDX_RESET_CONTROL ||
			idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
	endfunction : mapped

	function automatic pbdr_state_type reset_state();
		pbdr_state_type r;
		r = '0;
		r.ipg_len = IPG_RESET;
		r.pkt_len = PKT_LEN_RESET;
		r.irq_mask = IRQ_MASK_RESET;
		reset_state = r;
	endfunction : reset_state

	assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
		paddr: paddr_in, pwdata: pwdata_in};
	assign phy = '{byte_error: prbs_byte_error_in, count_mode: prbs_count_mode_in,
		lock_write: selftest_lock_write_in, diag_done: diag_done_in,
		diag_fail: diag_fail_in, quality: link_quality_in};

	always_comb begin
		logic wr;
		logic setup;
		logic [7:0] idx;
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		logic [15:0] rd;
		wr = 1'b0;
		setup = 1'b0;
		idx = 8'h00;
		ev = '0;
		clr = '0;
		rd = 16'h0000;
		s_d = s_q;
		idx = reg_index(req.paddr);
		setup = req.psel && !req.penable;
		wr = req.psel && req.penable && req.pwrite && mapped(req.paddr);
		s_d.quality = phy.quality; // [R12]

		// checker error count, saturating or wrapping
		if (phy.byte_error) begin
			if (phy.count_mode || s_q.err_cnt != ERRCNT_MAX) begin // [R3]
				s_d.err_cnt = s_q.err_cnt + 8'h01; // [R1]
			end
			if (!phy.count_mode && s_q.err_cnt == ERRCNT_MAX - 8'h01) begin
				ev[IRQ_SAT_BIT] = 1'b1;
			end
		end
		if (phy.lock_write) begin
			s_d.err_shown = s_q.err_cnt; // [R2]
			s_d.locked = 1'b1; // [R2]
		end

		// cable diagnostic completion
		if (s_q.diag_start && phy.diag_done) begin
			s_d.diag_start = 1'b0; // [R9]
			s_d.diag_done = 1'b1; // [R10]
			s_d.diag_fail = phy.diag_fail; // [R11]
			ev[IRQ_DONE_BIT] = 1'b1;
			ev[IRQ_FAIL_BIT] = phy.diag_fail;
		end

		if (wr) begin
			case (idx)
				IDX_ERRCOUNT_GAP: begin
					s_d.ipg_len = req.pwdata[7:0]; // [R5]
					if (req.pwdata[ERRCNT_CLEAR_BIT]) begin
						s_d.err_shown = s_q.err_cnt; // [R4]
						s_d.locked = 1'b1;
						s_d.err_cnt = 8'h00; // [R4]
					end else begin
						s_d.locked = 1'b0;
					end
				end
				IDX_PACKET_LENGTH: begin
					s_d.pkt_len = req.pwdata[10:0]; // [R6]
				end
				IDX_CABLE_DIAG: begin
					if (req.pwdata[DIAG_START_BIT] && !s_q.diag_start) begin
						s_d.diag_start = 1'b1; // [R8]
						s_d.diag_done = 1'b0; // [R16]
						s_d.diag_fail = 1'b0; // [R16]
					end else if (!req.pwdata[DIAG_START_BIT]) begin
						s_d.diag_start = 1'b0; // [R8]
					end
				end
				IDX_RESET_CONTROL: begin
					if (!s_q.rst_busy &&
						(req.pwdata[SOFT_RESET_BIT] || req.pwdata[SOFT_RESTART_BIT])) begin
						s_d.rst_busy = 1'b1;
						s_d.rst_full = req.pwdata[SOFT_RESET_BIT]; // [R14]
						s_d.rst_cnt = RST_CNT_W'(RESET_CYCLES - 1);
					end
				end
				IDX_IRQ_STATUS: begin
					clr = req.pwdata[IRQ_W-1:0];
				end
				IDX_IRQ_MASK: begin
					s_d.irq_mask = req.pwdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// an event in the clearing cycle stays set
		s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;

		// read data captured in the setup phase; reserved bits stay zero
		if (setup) begin
			case (idx)
				IDX_ERRCOUNT_GAP: begin
					rd[15:ERRCNT_LSB] = s_q.locked ? s_q.err_shown : s_q.err_cnt; // [R1]
					rd[7:0] = s_q.ipg_len;
				end
				IDX_PACKET_LENGTH: begin
					rd[10:0] = s_q.pkt_len; // [R7]
				end
				IDX_CABLE_DIAG: begin
					rd[DIAG_START_BIT] = s_q.diag_start;
					rd[QUALITY_LSB+1:QUALITY_LSB] = s_q.quality; // [R12]
					rd[DIAG_DONE_BIT] = s_q.diag_done;
					rd[DIAG_FAIL_BIT] = s_q.diag_fail; // [R11]
				end
				IDX_RESET_CONTROL: begin
					rd[SOFT_RESET_BIT] = s_q.rst_busy && s_q.rst_full; // [R17]
					rd[SOFT_RESTART_BIT] = s_q.rst_busy && !s_q.rst_full; // [R17]
				end
				IDX_IRQ_STATUS: begin
					rd[IRQ_W-1:0] = s_q.irq_stat;
				end
				IDX_IRQ_MASK: begin
					rd[IRQ_W-1:0] = s_q.irq_mask;
				end
				default: begin
				end
			endcase
			s_d.prdata = {16'h0000, rd};
		end

		// software reset or restart pulse
		if (s_q.rst_busy) begin
			if (s_q.rst_cnt == '0) begin
				s_d.rst_busy = 1'b0; // [R17]
				if (s_q.rst_full) begin
					s_d = reset_state(); // [R14]
				end
			end else begin
				s_d.rst_cnt = s_q.rst_cnt - RST_CNT_W'(1);
			end
			if (!s_q.rst_full) begin
				s_d.diag_start = 1'b0; // [R15]
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= reset_state();
		end else begin
			s_q <= s_d;
		end
	end

	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped(paddr_in);
	assign prdata_out = s_q.prdata;
	assign ipg_len_out = s_q.ipg_len;
	assign pkt_len_out = s_q.pkt_len;
	assign diag_start_out = s_q.diag_start;
	assign phy_reset_out = s_q.rst_busy && s_q.rst_full; // [R14]
	assign phy_restart_out = s_q.rst_busy && !s_q.rst_full; // [R15]
	assign irq_out = |(s_q.irq_stat & s_q.irq_mask);

endmodule : pbdr_regs

/* pkg/pbdr_pkg.sv */
package pbdr_pkg;

	// register indexes; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_ERRCOUNT_GAP = 8'h1B;
	localparam logic [7:0] IDX_PACKET_LENGTH = 8'h1C;
	localparam logic [7:0] IDX_CABLE_DIAG = 8'h1E;
	localparam logic [7:0] IDX_RESET_CONTROL = 8'h1F;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

	// field positions
	localparam int ERRCNT_LSB = 8;
	localparam int ERRCNT_CLEAR_BIT = 15;
	localparam int DIAG_START_BIT = 15;
	localparam int QUALITY_LSB = 8;
	localparam int DIAG_DONE_BIT = 1;
	localparam int DIAG_FAIL_BIT = 0;
	localparam int SOFT_RESET_BIT = 15;
	localparam int SOFT_RESTART_BIT = 14;

	// interrupt status and mask layout
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;
	localparam int IRQ_SAT_BIT = 2;
	localparam int IRQ_W = 3;

	// reset values and error count ceiling
	localparam logic [7:0] IPG_RESET = 8'h7D;
	localparam logic [10:0] PKT_LEN_RESET = 11'h5DC;
	localparam logic [7:0] ERRCNT_MAX = 8'hFF;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

	// timing: length of the internal reset pulse from a software reset or restart
	localparam int CLK_PERIOD_NS = 5;
	localparam int RESET_PULSE_NS = 80;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 8;

	typedef struct packed {
		logic [7:0] err_cnt;
		logic [7:0] err_shown;
		logic locked;
		logic [7:0] ipg_len;
		logic [10:0] pkt_len;
		logic diag_start;
		logic diag_done;
		logic diag_fail;
		logic [1:0] quality;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0] prdata;
		logic [RST_CNT_W-1:0] rst_cnt;
		logic rst_busy;
		logic rst_full;
	} pbdr_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [9:0] paddr;
		logic [31:0] pwdata;
	} pbdr_apb_req_type;

	typedef struct packed {
		logic byte_error;
		logic count_mode;
		logic lock_write;
		logic diag_done;
		logic diag_fail;
		logic [1:0] quality;
	} pbdr_phy_in_type;

endpackage : pbdr_pkg
